/* logic/cmif_pkg.sv */
// constants shared by the capture / mask / flag block and its helpers
// assumes a 32-bit apb slave with byte addresses on an 8-bit paddr
package cmif_pkg;
    // bus geometry
    localparam int CMIF_AW = 8;
    localparam int CMIF_DW = 32;
    localparam int CMIF_CW = 16;
    localparam int CMIF_SPAN_W = 8;
    localparam int CMIF_FW = 8;

    // register byte offsets
    localparam logic [CMIF_AW-1:0] CMIF_OFF_IRQ_EN = 8'h00;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_FLAGS = 8'h04;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_COUNTER = 8'h08;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CMP_A = 8'h0c;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CMP_B = 8'h10;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CAP_A = 8'h14;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CAP_B = 8'h18;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CAP_C = 8'h1c;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CAP_D = 8'h20;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_SPAN = 8'h24;
    localparam logic [CMIF_AW-1:0] CMIF_OFF_CTRL = 8'h28;

    // reset values and the counter maximum
    localparam logic [CMIF_FW-1:0] CMIF_IRQ_EN_RST = 8'h01;
    localparam logic [CMIF_FW-1:0] CMIF_FLAGS_RST = 8'h00;
    localparam logic [CMIF_CW-1:0] CMIF_CNT_RST = 16'h0000;
    localparam logic [CMIF_CW-1:0] CMIF_CMP_RST = 16'hffff;
    localparam logic [CMIF_CW-1:0] CMIF_CNT_MAX = 16'hffff;
    localparam logic [CMIF_SPAN_W-1:0] CMIF_SPAN_RST = 8'h00;
    localparam logic [CMIF_FW-1:0] CMIF_CTRL_RST = 8'h00;

    // flag register bit positions (irq enable uses the same ones)
    localparam int CMIF_B_CAP_A = 7;
    localparam int CMIF_B_CAP_B = 6;
    localparam int CMIF_B_CAP_C = 5;
    localparam int CMIF_B_CAP_D = 4;
    localparam int CMIF_B_CMP_A = 3;
    localparam int CMIF_B_CMP_B = 2;
    localparam int CMIF_B_WRAP = 1;
    localparam int CMIF_B_CLR_SEL = 0;
    localparam logic [CMIF_FW-1:0] CMIF_EVT_MASK = 8'hfe;

    // control register bit positions
    localparam int CMIF_C_EDGE_A = 7;
    localparam int CMIF_C_EDGE_B = 6;
    localparam int CMIF_C_EDGE_C = 5;
    localparam int CMIF_C_EDGE_D = 4;
    localparam int CMIF_C_BUF_A = 3;
    localparam int CMIF_C_BUF_B = 2;
    localparam int CMIF_C_MASK_MODE = 0;
endpackage

/* logic/cmif_mask_if.sv */
// signals between the capture logic and the capture d mask window
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface cmif_mask_if;
    import cmif_pkg::*;
    logic start;
    logic mode;
    logic [CMIF_CW-1:0] base;
    logic [CMIF_SPAN_W-1:0] span;
    logic active;
    modport owner (output start, output mode, output base, output span, input active);
    modport window (input start, input mode, input base, input span, output active);
endinterface

/* logic/cmif_edge.sv */
// capture pin synchroniser and selected-edge detector
// assumes the pin is asynchronous to clk_i
`timescale 1ns/1ps
module cmif_edge (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // pin and edge choice
    input wire logic pin_i,
    input wire logic rise_sel_i,
    // one-cycle pulse on the chosen edge
    output logic edge_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic lvl_q;

    // three stage synchroniser; s1 feeds only s2
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= pin_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // settled level only moves once stages two and three agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lvl_q <= 1'b0;
        end else if (s2_q == s3_q) begin
            lvl_q <= s2_q;
        end
    end

    assign edge_o = (s2_q == s3_q) && (s2_q != lvl_q) && (s2_q == rise_sel_i);
endmodule

/* logic/cmif_mask.sv */
// capture d mask window: opens on an accepted capture, closes on match
// assumes counter_i is the running free counter on the same clock
`timescale 1ns/1ps
module cmif_mask
    import cmif_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic standby_i,
    // running counter
    input wire logic [cmif_pkg::CMIF_CW-1:0] counter_i,
    // capture side
    cmif_mask_if.window mk
);
    import cmif_pkg::*;
    logic [CMIF_CW-1:0] end_q;
    logic active_q;
    logic [CMIF_CW-1:0] span2;

    // twice the span, widened to counter width
    assign span2 = {{(CMIF_CW-CMIF_SPAN_W-1){1'b0}}, mk.span, 1'b0};

    // window state; a zero span never opens it
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            active_q <= 1'b0;
            end_q <= CMIF_CNT_RST;
        end else if (standby_i) begin
            active_q <= 1'b0;
            end_q <= CMIF_CNT_RST;
        end else if (mk.start && mk.mode && (mk.span != CMIF_SPAN_RST)) begin
            active_q <= 1'b1;
            end_q <= mk.base + span2;
        end else if (active_q && (counter_i == end_q)) begin
            active_q <= 1'b0;
        end
    end

    assign mk.active = active_q;
endmodule

/* logic/cmif_top.sv */
// free timer capture, compare, mask window and flag/enable registers
// assumes an apb master on clk_i and capture pins from outside the chip
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
module cmif_top
    import cmif_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic standby_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cmif_pkg::CMIF_AW-1:0] paddr_i,
    input wire logic [cmif_pkg::CMIF_DW-1:0] pwdata_i,
    output logic [cmif_pkg::CMIF_DW-1:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // counter advance pulse from the clock selector
    input wire logic count_tick_i,
    // capture pins
    input wire logic capture_a_pin_i,
    input wire logic capture_b_pin_i,
    input wire logic capture_c_pin_i,
    input wire logic capture_d_pin_i,
    // interrupt requests
    output logic cap_a_irq_o,
    output logic cap_b_irq_o,
    output logic cap_c_irq_o,
    output logic cap_d_irq_o,
    output logic cmp_a_irq_o,
    output logic cmp_b_irq_o,
    output logic wrap_irq_o,
    // compare match strobes for the output pins
    output logic cmp_a_match_o,
    output logic cmp_b_match_o
);
    import cmif_pkg::*;

    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [CMIF_FW-1:0] irq_enable_reg_q;
    logic [CMIF_FW-1:0] timer_flag_reg_q;
    logic [CMIF_FW-1:0] timer_flag_reg_d;
    logic [CMIF_FW-1:0] armed_q;
    logic [CMIF_CW-1:0] free_counter_q;
    logic [CMIF_CW-1:0] compare_a_reg_q;
    logic [CMIF_CW-1:0] compare_b_reg_q;
    logic [CMIF_CW-1:0] capture_a_reg_q;
    logic [CMIF_CW-1:0] capture_b_reg_q;
    logic [CMIF_CW-1:0] capture_c_reg_q;
    logic [CMIF_CW-1:0] capture_d_reg_q;
    logic [CMIF_SPAN_W-1:0] capture_mask_span_reg_q;
    logic [CMIF_FW-1:0] ctrl_q;
    logic [CMIF_DW-1:0] prdata_q;
    logic [CMIF_FW-1:0] set_evt;

    // ------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------
    logic setup_rd;
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    logic [CMIF_DW-1:0] rd_mux;

    assign setup_rd = psel_i && !penable_i && !pwrite_i;
    assign acc = psel_i && penable_i;
    assign wr = acc && pwrite_i;
    assign rd = acc && !pwrite_i;

    // register lookup; unmapped reads return zero with an error
    always_comb begin
        mapped = 1'b1;
        rd_mux = '0;
        case (paddr_i)
            CMIF_OFF_IRQ_EN: rd_mux[CMIF_FW-1:0] = irq_enable_reg_q | CMIF_IRQ_EN_RST;
            CMIF_OFF_FLAGS: rd_mux[CMIF_FW-1:0] = timer_flag_reg_q;
            CMIF_OFF_COUNTER: rd_mux[CMIF_CW-1:0] = free_counter_q;
            CMIF_OFF_CMP_A: rd_mux[CMIF_CW-1:0] = compare_a_reg_q;
            CMIF_OFF_CMP_B: rd_mux[CMIF_CW-1:0] = compare_b_reg_q;
            CMIF_OFF_CAP_A: rd_mux[CMIF_CW-1:0] = capture_a_reg_q;
            CMIF_OFF_CAP_B: rd_mux[CMIF_CW-1:0] = capture_b_reg_q;
            CMIF_OFF_CAP_C: rd_mux[CMIF_CW-1:0] = capture_c_reg_q;
            CMIF_OFF_CAP_D: rd_mux[CMIF_CW-1:0] = capture_d_reg_q;
            CMIF_OFF_SPAN: rd_mux[CMIF_SPAN_W-1:0] = capture_mask_span_reg_q;
            CMIF_OFF_CTRL: rd_mux[CMIF_FW-1:0] = ctrl_q;
            default: mapped = 1'b0;
        endcase
    end

    // read data latched in the setup cycle so prdata comes from a flop
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= '0;
        end else if (setup_rd) begin
            prdata_q <= rd_mux;
        end
    end

    assign prdata_o = prdata_q;
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !mapped;

    // ------------------------------------------------------------
    // capture pins
    // ------------------------------------------------------------
    logic [3:0] pin_vec;
    logic [3:0] rise_vec;
    logic [3:0] edge_vec;
    logic cap_a_evt;
    logic cap_b_evt;
    logic cap_c_evt;
    logic cap_d_evt;

    assign pin_vec = {capture_a_pin_i, capture_b_pin_i, capture_c_pin_i, capture_d_pin_i};
    assign rise_vec = ctrl_q[CMIF_C_EDGE_A:CMIF_C_EDGE_D];

    // one synchroniser and edge picker per capture channel
    for (genvar g = 0; g < 4; g++) begin : g_pin
        cmif_edge u_edge (
            .clk_i(clk_i),
            .rst_n_i(rst_n_i),
            .pin_i(pin_vec[g]),
            .rise_sel_i(rise_vec[g]),
            .edge_o(edge_vec[g])
        );
    end

    cmif_mask_if mk ();

    assign cap_a_evt = edge_vec[3];
    assign cap_b_evt = edge_vec[2];
    assign cap_c_evt = edge_vec[1];
    assign cap_d_evt = edge_vec[0] && !mk.active;

    // ------------------------------------------------------------
    // mask window
    // ------------------------------------------------------------
    assign mk.start = cap_d_evt;
    assign mk.mode = ctrl_q[CMIF_C_MASK_MODE];
    assign mk.base = free_counter_q; // value stored into capture d at the event when b is not buffered
    assign mk.span = capture_mask_span_reg_q;

    cmif_mask u_mask (
        .clk_i(clk_i),
        .rst_n_i(rst_n_i),
        .standby_i(standby_i),
        .counter_i(free_counter_q),
        .mk(mk)
    );

    // ------------------------------------------------------------
    // counter and compare
    // ------------------------------------------------------------
    logic match_a;
    logic match_b;
    logic wrap;

    assign match_a = (free_counter_q == compare_a_reg_q);
    assign match_b = (free_counter_q == compare_b_reg_q);
    assign cmp_a_match_o = match_a;
    assign cmp_b_match_o = match_b;
    // clearing on match takes the counter to zero but is not a wrap
    assign wrap = count_tick_i && (free_counter_q == CMIF_CNT_MAX)
        && !(match_a && timer_flag_reg_q[CMIF_B_CLR_SEL]);

    // software write beats the tick
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            free_counter_q <= CMIF_CNT_RST;
        end else if (standby_i) begin
            free_counter_q <= CMIF_CNT_RST;
        end else if (wr && paddr_i == CMIF_OFF_COUNTER) begin
            free_counter_q <= pwdata_i[CMIF_CW-1:0];
        end else if (count_tick_i) begin
            if (match_a && timer_flag_reg_q[CMIF_B_CLR_SEL]) begin
                free_counter_q <= CMIF_CNT_RST;
            end else begin
                free_counter_q <= free_counter_q + 16'h0001;
            end
        end
    end

    // compare registers
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            compare_a_reg_q <= CMIF_CMP_RST;
            compare_b_reg_q <= CMIF_CMP_RST;
        end else if (standby_i) begin
            compare_a_reg_q <= CMIF_CMP_RST;
            compare_b_reg_q <= CMIF_CMP_RST;
        end else if (wr && paddr_i == CMIF_OFF_CMP_A) begin
            compare_a_reg_q <= pwdata_i[CMIF_CW-1:0];
        end else if (wr && paddr_i == CMIF_OFF_CMP_B) begin
            compare_b_reg_q <= pwdata_i[CMIF_CW-1:0];
        end
    end

    // ------------------------------------------------------------
    // capture registers
    // ------------------------------------------------------------
    // buffered a: old a moves to c; pin c then only flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_a_reg_q <= CMIF_CNT_RST;
            capture_c_reg_q <= CMIF_CNT_RST;
        end else if (standby_i) begin
            capture_a_reg_q <= CMIF_CNT_RST;
            capture_c_reg_q <= CMIF_CNT_RST;
        end else begin
            if (cap_a_evt) begin
                capture_a_reg_q <= free_counter_q;
            end
            if (ctrl_q[CMIF_C_BUF_A]) begin
                if (cap_a_evt) begin
                    capture_c_reg_q <= capture_a_reg_q;
                end
            end else if (cap_c_evt) begin
                capture_c_reg_q <= free_counter_q;
            end
        end
    end

    // buffered b: old b moves to d; pin d then only flags and starts the mask window
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_b_reg_q <= CMIF_CNT_RST;
            capture_d_reg_q <= CMIF_CNT_RST;
        end else if (standby_i) begin
            capture_b_reg_q <= CMIF_CNT_RST;
            capture_d_reg_q <= CMIF_CNT_RST;
        end else begin
            if (cap_b_evt) begin
                capture_b_reg_q <= free_counter_q;
            end
            if (ctrl_q[CMIF_C_BUF_B]) begin
                if (cap_b_evt) begin
                    capture_d_reg_q <= capture_b_reg_q;
                end
            end else if (cap_d_evt) begin
                capture_d_reg_q <= free_counter_q;
            end
        end
    end

    // ------------------------------------------------------------
    // control, span and enable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            capture_mask_span_reg_q <= CMIF_SPAN_RST;
        end else if (standby_i) begin
            capture_mask_span_reg_q <= CMIF_SPAN_RST;
        end else if (wr && paddr_i == CMIF_OFF_SPAN) begin
            capture_mask_span_reg_q <= pwdata_i[CMIF_SPAN_W-1:0];
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ctrl_q <= CMIF_CTRL_RST;
        end else if (standby_i) begin
            ctrl_q <= CMIF_CTRL_RST;
        end else if (wr && paddr_i == CMIF_OFF_CTRL) begin
            ctrl_q <= pwdata_i[CMIF_FW-1:0];
        end
    end

    // bit 0 is held at one whatever is written
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_enable_reg_q <= CMIF_IRQ_EN_RST;
        end else if (standby_i) begin
            irq_enable_reg_q <= CMIF_IRQ_EN_RST;
        end else if (wr && paddr_i == CMIF_OFF_IRQ_EN) begin
            irq_enable_reg_q <= pwdata_i[CMIF_FW-1:0] | CMIF_IRQ_EN_RST;
        end
    end

    // ------------------------------------------------------------
    // flags
    // ------------------------------------------------------------
    assign set_evt = {cap_a_evt, cap_b_evt, cap_c_evt, cap_d_evt,
        match_a, match_b, wrap, 1'b0};

    // a zero write clears only flags armed by an earlier read of one
    always_comb begin
        timer_flag_reg_d = timer_flag_reg_q;
        if (wr && paddr_i == CMIF_OFF_FLAGS) begin
            timer_flag_reg_d = timer_flag_reg_q & ~(armed_q & ~pwdata_i[CMIF_FW-1:0] & CMIF_EVT_MASK);
            timer_flag_reg_d[CMIF_B_CLR_SEL] = pwdata_i[CMIF_B_CLR_SEL];
        end
        timer_flag_reg_d = timer_flag_reg_d | set_evt;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_flag_reg_q <= CMIF_FLAGS_RST;
        end else if (standby_i) begin
            timer_flag_reg_q <= CMIF_FLAGS_RST;
        end else begin
            timer_flag_reg_q <= timer_flag_reg_d;
        end
    end

    // arming uses the value the reader actually saw
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed_q <= CMIF_FLAGS_RST;
        end else if (standby_i) begin
            armed_q <= CMIF_FLAGS_RST;
        end else if (wr && paddr_i == CMIF_OFF_FLAGS) begin
            armed_q <= CMIF_FLAGS_RST;
        end else if (rd && paddr_i == CMIF_OFF_FLAGS) begin
            armed_q <= armed_q | (prdata_q[CMIF_FW-1:0] & CMIF_EVT_MASK);
        end
    end

    // ------------------------------------------------------------
    // interrupt requests
    // ------------------------------------------------------------
    assign cap_a_irq_o = timer_flag_reg_q[CMIF_B_CAP_A] && irq_enable_reg_q[CMIF_B_CAP_A];
    assign cap_b_irq_o = timer_flag_reg_q[CMIF_B_CAP_B] && irq_enable_reg_q[CMIF_B_CAP_B];
    assign cap_c_irq_o = timer_flag_reg_q[CMIF_B_CAP_C] && irq_enable_reg_q[CMIF_B_CAP_C];
    assign cap_d_irq_o = timer_flag_reg_q[CMIF_B_CAP_D] && irq_enable_reg_q[CMIF_B_CAP_D];
    assign cmp_a_irq_o = timer_flag_reg_q[CMIF_B_CMP_A] && irq_enable_reg_q[CMIF_B_CMP_A];
    assign cmp_b_irq_o = timer_flag_reg_q[CMIF_B_CMP_B] && irq_enable_reg_q[CMIF_B_CMP_B];
    assign wrap_irq_o = timer_flag_reg_q[CMIF_B_WRAP] && irq_enable_reg_q[CMIF_B_WRAP];
endmodule

/* verif/cmif_monitor.sv */
// checker for the capture / mask / flag block, bound to its top ports
// assumes apb writes land on the access-phase edge, no wait states
`timescale 1ns/1ps
module cmif_monitor
    import cmif_pkg::*;
(
    // clock and resets
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic standby_i,
    // apb
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [cmif_pkg::CMIF_AW-1:0] paddr_i,
    input wire logic [cmif_pkg::CMIF_DW-1:0] pwdata_i,
    input wire logic [cmif_pkg::CMIF_DW-1:0] prdata_o,
    // requests and match
    input wire logic cap_a_irq_o,
    input wire logic cap_b_irq_o,
    input wire logic cap_c_irq_o,
    input wire logic cap_d_irq_o,
    input wire logic cmp_a_irq_o,
    input wire logic cmp_b_irq_o,
    input wire logic wrap_irq_o,
    input wire logic cmp_a_match_o
);
    import cmif_pkg::*;
    // ------------------------------
    // enable shadow
    // ------------------------------
    logic [7:0] en_q;
    logic en_wr;
    // kept from bus writes so gating is judged without looking inside
    assign en_wr = psel_i && penable_i && pwrite_i && paddr_i == CMIF_OFF_IRQ_EN;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            en_q <= CMIF_IRQ_EN_RST;
        else if (standby_i)
            en_q <= CMIF_IRQ_EN_RST;
        else if (en_wr)
            en_q <= pwdata_i[7:0];
    end
    // ------------------------------
    // properties
    // ------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // access phase of a read at one offset
    sequence rd_at(logic [7:0] a);
        psel_i && penable_i && !pwrite_i && paddr_i == a;
    endsequence
    // a match with its enable on and no enable change pending
    sequence hit(logic m, logic e);
        m && e && !en_wr && !standby_i;
    endsequence
    span_read_a: assert property (rd_at(CMIF_OFF_SPAN) |-> prdata_o[31:8] == 24'h0)
        else $error("span upper bits set");
    en_read_a: assert property (rd_at(CMIF_OFF_IRQ_EN) |-> prdata_o == {24'h0, en_q[7:1], 1'b1})
        else $error("enable read wrong");
    flag_read_a: assert property (rd_at(CMIF_OFF_FLAGS) |-> prdata_o[31:8] == 24'h0)
        else $error("flag upper bits set");
    cap_gate_a: assert property (
        ({cap_a_irq_o, cap_b_irq_o, cap_c_irq_o, cap_d_irq_o} & ~en_q[7:4]) == 4'h0)
        else $error("capture request while disabled");
    cmp_a_set_a: assert property (hit(cmp_a_match_o, en_q[3]) |=> cmp_a_irq_o)
        else $error("compare a match gave no request");
    wrap_gate_a: assert property (wrap_irq_o |-> en_q[1])
        else $error("wrap request while disabled");
    cmp_b_gate_a: assert property (cmp_b_irq_o |-> en_q[2])
        else $error("compare b request while disabled");
    standby_clr_a: assert property (
        standby_i |=> {cap_a_irq_o, cap_b_irq_o, cap_c_irq_o, cap_d_irq_o, cmp_a_irq_o, cmp_b_irq_o,
        wrap_irq_o, cmp_a_match_o} == 8'h0)
        else $error("standby left state behind");
endmodule

/* verif/test_capture_mask_irq_flags.sv */
// self-checking bench for the capture / mask / flag block over apb
// assumes the package, design and monitor are compiled first
`timescale 1ns/1ps
module test_capture_mask_irq_flags;
    import cmif_pkg::*;
    // ------------------------------
    // signals
    // ------------------------------
    logic clk, rst_n, stby, psel, pen, pwr, tick, err;
    logic [7:0] addr;
    logic [31:0] wdata, rdata, rd;
    logic [3:0] pin;
    logic [6:0] irq;
    logic rdy, mat_a, mat_b, slv_err;
    int n_fail, n_compared;
    cmif_top dut (
        .clk_i(clk), .rst_n_i(rst_n), .standby_i(stby), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(addr), .pwdata_i(wdata), .prdata_o(rdata), .pready_o(rdy), .pslverr_o(err),
        .count_tick_i(tick), .capture_a_pin_i(pin[3]), .capture_b_pin_i(pin[2]), .capture_c_pin_i(pin[1]),
        .capture_d_pin_i(pin[0]), .cap_a_irq_o(irq[6]), .cap_b_irq_o(irq[5]), .cap_c_irq_o(irq[4]),
        .cap_d_irq_o(irq[3]), .cmp_a_irq_o(irq[2]), .cmp_b_irq_o(irq[1]), .wrap_irq_o(irq[0]),
        .cmp_a_match_o(mat_a), .cmp_b_match_o(mat_b)
    );
    // free-running clock, 4 ns
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------
    // tasks
    // ------------------------------
    task automatic end_sim();
        if (n_fail == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        psel <= 1'b1;
        pwr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        while (rdy !== 1'b1) begin
            n++;
            if (n > 16) begin
                n_fail++;
                end_sim();
            end
            @(posedge clk);
        end
        // error is combinational, so it is only valid while the access phase stands
        rd = rdata;
        slv_err = err;
        psel <= 1'b0;
        pen <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // read arms every set flag, the zero write then clears them
    task automatic clr();
        xfer(1'b0, 8'h04, 32'h0);
        wr(8'h04, 32'h0);
    endtask
    // pulse held well past the synchroniser, rising edge first
    task automatic pulse(input int i);
        pin[i] <= 1'b1;
        repeat (6) @(posedge clk);
        pin[i] <= 1'b0;
        repeat (6) @(posedge clk);
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        {rst_n, stby, psel, pen, pwr, tick, pin, addr, wdata} = 50'h0;
        n_fail = 0;
        n_compared = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rc(8'h00, 32'h01);
        rc(8'h04, 32'h00);
        rc(8'h24, 32'h00);
        rc(8'hfc, 32'h00);
        chk({31'h0, slv_err}, 32'h1);
        wr(8'h00, 32'hfffffffe);
        rc(8'h00, 32'hff);
        wr(8'h24, 32'habcd);
        rc(8'h24, 32'hcd);
        wr(8'h0c, 32'h5);
        wr(8'h10, 32'h7);
        wr(8'h08, 32'h5);
        chk({31'h0, mat_a}, 32'h1);
        clr();
        rc(8'h04, 32'h08);
        wr(8'h08, 32'h7);
        chk({31'h0, mat_b}, 32'h1);
        wr(8'h08, 32'h8);
        rc(8'h04, 32'h0c);
        chk({25'h0, irq}, 32'h06);
        wr(8'h04, 32'hff);
        wr(8'h04, 32'h00);
        rc(8'h04, 32'h0c);
        wr(8'h04, 32'h08);
        rc(8'h04, 32'h08);
        wr(8'h00, 32'h01);
        chk({25'h0, irq}, 32'h0);
        wr(8'h08, 32'hffff);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        rc(8'h08, 32'h0);
        rc(8'h04, 32'h0a);
        wr(8'h00, 32'h02);
        chk({25'h0, irq}, 32'h01);
        wr(8'h04, 32'h01);
        wr(8'h08, 32'h5);
        tick <= 1'b1;
        @(posedge clk);
        tick <= 1'b0;
        rc(8'h08, 32'h0);
        rc(8'h04, 32'h09);
        clr();
        wr(8'h28, 32'h70); // capture a on the falling edge
        wr(8'h08, 32'h0100);
        pulse(3);
        rc(8'h14, 32'h0100);
        wr(8'h28, 32'hfc);
        wr(8'h08, 32'h0200);
        pulse(3);
        rc(8'h1c, 32'h0100);
        pulse(1);
        rc(8'h1c, 32'h0100);
        wr(8'h08, 32'h0300);
        pulse(2);
        wr(8'h08, 32'h0400);
        pulse(2);
        rc(8'h20, 32'h0300);
        pulse(0);
        rc(8'h20, 32'h0300);
        rc(8'h04, 32'hf0);
        wr(8'h00, 32'hff);
        chk({25'h0, irq}, 32'h78);
        clr();
        wr(8'h28, 32'hf1);
        wr(8'h24, 32'h4);
        wr(8'h08, 32'h1000);
        pulse(0);
        rc(8'h20, 32'h1000);
        clr();
        wr(8'h08, 32'h1004);
        pulse(0);
        rc(8'h20, 32'h1000);
        rc(8'h04, 32'h00);
        wr(8'h08, 32'h1008);
        wr(8'h08, 32'h1009);
        pulse(0);
        rc(8'h20, 32'h1009);
        wr(8'h08, 32'h1011);
        wr(8'h24, 32'h0);
        pulse(0);
        wr(8'h08, 32'h2001);
        pulse(0);
        rc(8'h20, 32'h2001);
        wr(8'h24, 32'h55);
        stby <= 1'b1;
        @(posedge clk);
        stby <= 1'b0;
        @(posedge clk);
        rc(8'h00, 32'h01);
        rc(8'h04, 32'h00);
        rc(8'h24, 32'h00);
        end_sim();
    end
endmodule
// monitor on the block's top ports
bind cmif_top cmif_monitor mon (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .cap_a_irq_o(cap_a_irq_o), .cap_b_irq_o(cap_b_irq_o), .cap_c_irq_o(cap_c_irq_o),
    .cap_d_irq_o(cap_d_irq_o), .cmp_a_irq_o(cmp_a_irq_o), .cmp_b_irq_o(cmp_b_irq_o),
    .wrap_irq_o(wrap_irq_o), .cmp_a_match_o(cmp_a_match_o)
);
